/* File: logic/extended_smram_decode_control.v */
`timescale 1ns/1ps
`include "smram_decode_consts.vh"
//
// Functional notes
// R1 - high window remaps onto low legacy DRAM
// R2 - non-SMM extended access sets invalid flag; here not set while open and unlocked
// R3 - flag sticky; write one clears it
// R4 - three cacheability bits always read one
// R5 - size code selects 1, 2, 8 MB
// R6 - segment ends at low top minus stolen
// R7 - enabled segment: SMM to DRAM, else downstream
// R8 - segment exists only with both enables
// R9 - lock freezes high enable, size, enable
// R10 - size field is address bits 35:26
// R11 - size resets 001h, bits 15:10 zero
// R12 - control register resets to 38h
// R13 - lock cleared only by reset
// R14 - extended features need global enable
// R15 - reserved size code claims no segment
module extended_smram_decode_control (
   // clock and reset
   input  wire        clk_in,
   input  wire        rst_in,
   // configuration access, byte wide
   input  wire        cfg_wr_in,
   input  wire        cfg_rd_in,
   input  wire [7:0]  cfg_addr_in,
   input  wire [7:0]  cfg_wdata_in,
   output reg  [7:0]  cfg_rdata_out,
   // state from other address-map registers
   input  wire        global_smram_enable_in,
   input  wire        smm_lock_in,
   input  wire        smm_open_in,
   input  wire [15:0] low_usable_dram_top_mb_in,
   input  wire [15:0] stolen_mb_in,
   // host request, one cycle
   input  wire        req_valid_in,
   input  wire [35:0] req_addr_in,
   input  wire        req_smm_in,
   // decode result, registered
   output reg         dec_valid_out,
   output reg  [35:0] dec_addr_out,
   output reg         dec_to_dram_out,
   output reg         dec_to_link_out,
   // live register state
   output reg  [9:0]  top_of_memory_size_out,
   output reg         invalid_access_flag_out
);
   // -----------------------------------------------------------
   // control state
   // -----------------------------------------------------------
   reg        high_window_enable;
   reg [1:0]  top_segment_size;
   reg        top_segment_enable_alias;
   reg        invalid_access_flag;
   reg [9:0]  top_of_memory_size;
   // segment bounds from the range helper
   wire [15:0] seg_base_mb;
   wire [15:0] seg_end_mb;
   wire        seg_size_ok;
   // decode terms
   reg         high_hit;
   reg         seg_hit;
   reg         bad_access;
   reg [7:0]   ctrl_view;
   reg [7:0]   next_rdata;
   // write strobes
   reg         wr_ctrl;
   reg         wr_size_lo;
   reg         wr_size_hi;
   reg         ctrl_unlocked;

   // range arithmetic kept apart so its subtraction widths stay visible
   top_segment_range u_range (
      .low_top_mb_in (low_usable_dram_top_mb_in),
      .stolen_mb_in  (stolen_mb_in),
      .size_code_in  (top_segment_size),
      .base_mb_out   (seg_base_mb),
      .end_mb_out    (seg_end_mb),
      .valid_out     (seg_size_ok)
   );

   // -----------------------------------------------------------
   // address decode
   // -----------------------------------------------------------
   always @* begin
      high_hit = global_smram_enable_in && high_window_enable && // R14
                 req_addr_in >= `HIGH_WIN_BASE && req_addr_in <= `HIGH_WIN_LAST;
      seg_hit  = global_smram_enable_in && top_segment_enable_alias && seg_size_ok && // R8 R15
                 req_addr_in[35:20] >= seg_base_mb && req_addr_in[35:20] < seg_end_mb; // R6
      // open only relaxes the check while unlocked
      bad_access = req_valid_in && !req_smm_in && (high_hit || seg_hit) &&
                   !(smm_open_in && !smm_lock_in); // R2
   end

   // the register view: cache bits hardwired so no write can drop them
   always @* begin
      ctrl_view = 8'h00;
      ctrl_view[`ESMC_HIGH_EN_BIT]             = high_window_enable;
      ctrl_view[`ESMC_ERR_BIT]                 = invalid_access_flag;
      ctrl_view[`ESMC_CACHE_BIT]               = 1'b1; // R4
      ctrl_view[`ESMC_L1_BIT]                  = 1'b1; // R4
      ctrl_view[`ESMC_L2_BIT]                  = 1'b1; // R4
      ctrl_view[`ESMC_SIZE_HI:`ESMC_SIZE_LO]   = top_segment_size;
      ctrl_view[`ESMC_TOP_EN_BIT]              = top_segment_enable_alias;
      // unmapped offsets read zero
      case (cfg_addr_in)
         `ESMC_OFFSET:    next_rdata = ctrl_view;
         `TOMS_OFFSET_LO: next_rdata = top_of_memory_size[7:0];
         `TOMS_OFFSET_HI: next_rdata = {6'h00, top_of_memory_size[9:8]}; // R11
         default:         next_rdata = 8'h00;
      endcase
   end

   // -----------------------------------------------------------
   // write strobes
   // -----------------------------------------------------------
   // one strobe per register byte keeps the write processes short
   always @* begin
      wr_ctrl       = cfg_wr_in && cfg_addr_in == `ESMC_OFFSET;
      wr_size_lo    = cfg_wr_in && cfg_addr_in == `TOMS_OFFSET_LO;
      wr_size_hi    = cfg_wr_in && cfg_addr_in == `TOMS_OFFSET_HI;
      // lock is owned by the compatible control block; only its reset clears it
      ctrl_unlocked = !smm_lock_in; // R13
   end

   // -----------------------------------------------------------
   // control register fields
   // -----------------------------------------------------------
   // lock freezes the enables and the size; the flag stays clearable
   always @(posedge clk_in) begin
      if (rst_in) begin
         high_window_enable       <= `ESMC_HIGH_EN_RESET; // R12
         top_segment_size         <= `ESMC_SIZE_RESET; // R12
         top_segment_enable_alias <= `ESMC_TOP_EN_RESET; // R12
      end else if (wr_ctrl && ctrl_unlocked) begin // R9
         high_window_enable       <= cfg_wdata_in[`ESMC_HIGH_EN_BIT];
         top_segment_size         <= cfg_wdata_in[`ESMC_SIZE_HI:`ESMC_SIZE_LO];
         top_segment_enable_alias <= cfg_wdata_in[`ESMC_TOP_EN_BIT];
      end
   end

   // -----------------------------------------------------------
   // top of memory size
   // -----------------------------------------------------------
   // size register locks alongside the others, one byte lane at a time
   always @(posedge clk_in) begin
      if (rst_in) begin
         top_of_memory_size <= `TOMS_RESET; // R11
      end else begin
         if (wr_size_lo && ctrl_unlocked)
            top_of_memory_size[7:0] <= cfg_wdata_in; // R10
         if (wr_size_hi && ctrl_unlocked)
            top_of_memory_size[9:8] <= cfg_wdata_in[1:0]; // R10
      end
   end

   // -----------------------------------------------------------
   // invalid access flag
   // -----------------------------------------------------------
   // set beats a same-cycle clear so no event is lost
   always @(posedge clk_in) begin
      if (rst_in)
         invalid_access_flag <= `ESMC_ERR_RESET; // R12
      else if (bad_access)
         invalid_access_flag <= 1'b1; // R2
      else if (wr_ctrl && cfg_wdata_in[`ESMC_ERR_BIT])
         invalid_access_flag <= 1'b0; // R3
   end

   // -----------------------------------------------------------
   // read data
   // -----------------------------------------------------------
   // zero between reads so an idle bus never shows register contents
   always @(posedge clk_in) begin
      if (rst_in)
         cfg_rdata_out <= 8'h00;
      else
         cfg_rdata_out <= cfg_rd_in ? next_rdata : 8'h00;
   end

   // -----------------------------------------------------------
   // status copies
   // -----------------------------------------------------------
   // a cycle of lag buys outputs straight from flip-flops
   always @(posedge clk_in) begin
      if (rst_in) begin
         top_of_memory_size_out  <= `TOMS_RESET; // R11
         invalid_access_flag_out <= `ESMC_ERR_RESET;
      end else begin
         top_of_memory_size_out  <= top_of_memory_size;
         invalid_access_flag_out <= invalid_access_flag;
      end
   end

   // -----------------------------------------------------------
   // decode result
   // -----------------------------------------------------------
   // one result per request, standing for exactly one cycle
   always @(posedge clk_in) begin
      if (rst_in) begin
         dec_valid_out   <= 1'b0;
         dec_addr_out    <= 36'h000000000;
         dec_to_dram_out <= 1'b0;
         dec_to_link_out <= 1'b0;
      end else begin
         dec_valid_out   <= req_valid_in;
         dec_to_dram_out <= 1'b0;
         dec_to_link_out <= 1'b0;
         dec_addr_out    <= req_addr_in;
         if (req_valid_in) begin
            if (high_hit && req_smm_in) begin
               dec_addr_out    <= req_addr_in - `HIGH_WIN_BASE + `LOW_WIN_BASE; // R1
               dec_to_dram_out <= 1'b1;
            end else if (high_hit || seg_hit) begin
               // non-SMM hits leave for the link; the flag records them unless open while unlocked
               dec_to_dram_out <= req_smm_in; // R7
               dec_to_link_out <= !req_smm_in; // R7
            end else begin
               // outside extended ranges: ordinary DRAM, other decoders refine it
               dec_to_dram_out <= 1'b1;
            end
         end
      end
   end
endmodule

/* File: logic/top_segment_range.v */
`timescale 1ns/1ps
`include "smram_decode_consts.vh"
// computes the top segment range in 1 MB units from the size code
module top_segment_range (
   // configuration
   input  wire [15:0] low_top_mb_in,
   input  wire [15:0] stolen_mb_in,
   input  wire [1:0]  size_code_in,
   // range, end exclusive
   output reg  [15:0] base_mb_out,
   output reg  [15:0] end_mb_out,
   output reg         valid_out
);
   reg [15:0] size_mb;
   // -----------------------------------------------------------
   // range arithmetic
   // -----------------------------------------------------------
   always @* begin
      size_mb   = 16'h0000;
      valid_out = 1'b1;
      case (size_code_in) // R5
         `SEG_CODE_1MB: size_mb = `SEG_MB_1;
         `SEG_CODE_2MB: size_mb = `SEG_MB_2;
         `SEG_CODE_8MB: size_mb = `SEG_MB_8;
         default:        valid_out = 1'b0; // R15
      endcase
      end_mb_out  = low_top_mb_in - stolen_mb_in; // R6
      base_mb_out = end_mb_out - size_mb; // R6
   end
endmodule

/* File: shared/smram_decode_consts.vh */
`ifndef SMRAM_DECODE_CONSTS_VH
`define SMRAM_DECODE_CONSTS_VH
// register offsets in configuration space (byte addresses)
`define ESMC_OFFSET        8'h9E
`define TOMS_OFFSET_LO     8'hA0
`define TOMS_OFFSET_HI     8'hA1
// extended smram control field positions
`define ESMC_HIGH_EN_BIT   7
`define ESMC_ERR_BIT       6
`define ESMC_CACHE_BIT     5
`define ESMC_L1_BIT        4
`define ESMC_L2_BIT        3
`define ESMC_SIZE_HI       2
`define ESMC_SIZE_LO       1
`define ESMC_TOP_EN_BIT    0
// reset values
`define ESMC_RESET         8'h38
`define TOMS_RESET         10'h001
// per-field reset values, together giving the control reset above
`define ESMC_HIGH_EN_RESET 1'b0
`define ESMC_ERR_RESET     1'b0
`define ESMC_SIZE_RESET    2'h0
`define ESMC_TOP_EN_RESET  1'b0
// top segment size codes
`define SEG_CODE_1MB       2'h0
`define SEG_CODE_2MB       2'h1
`define SEG_CODE_8MB       2'h2
// sizes as address-bit-35:20 counts of 1 MB
`define SEG_MB_1           16'h0001
`define SEG_MB_2           16'h0002
`define SEG_MB_8           16'h0008
// high window and its low legacy target
`define HIGH_WIN_BASE      36'h0FEDA0000
`define HIGH_WIN_LAST      36'h0FEDBFFFF
`define LOW_WIN_BASE       36'h0000A0000
`endif

/* File: tb/extended_smram_decode_control_tb_top.sv */
`timescale 1ns/1ps
module extended_smram_decode_control_tb_top;
   reg         clk_in, rst_in, cfg_wr_in, cfg_rd_in, global_smram_enable_in, smm_lock_in, req_valid_in, req_smm_in;
   reg  [7:0]  cfg_addr_in, cfg_wdata_in;
   reg  [35:0] req_addr_in;
   reg  [73:0] rows [0:7];
   wire [7:0]  cfg_rdata_out;
   wire [35:0] dec_addr_out;
   wire [9:0]  top_of_memory_size_out;
   wire [31:0] link_hits;
   wire        dec_valid_out, dec_to_dram_out, dec_to_link_out, invalid_access_flag_out;
   reg         smm_open_in;
   wire [15:0] low_usable_dram_top_mb_in = 16'h0800;
   wire [15:0] stolen_mb_in = 16'h0002;
   integer     n_errors, check_count, exp_links, i;
   reg  [15:0] base;
   extended_smram_decode_control dut (
      .clk_in                    (clk_in),
      .rst_in                    (rst_in),
      .cfg_wr_in                 (cfg_wr_in),
      .cfg_rd_in                 (cfg_rd_in),
      .cfg_addr_in               (cfg_addr_in),
      .cfg_wdata_in              (cfg_wdata_in),
      .cfg_rdata_out             (cfg_rdata_out),
      .global_smram_enable_in    (global_smram_enable_in),
      .smm_lock_in               (smm_lock_in),
      .smm_open_in               (smm_open_in),
      .low_usable_dram_top_mb_in (low_usable_dram_top_mb_in),
      .stolen_mb_in              (stolen_mb_in),
      .req_valid_in              (req_valid_in),
      .req_addr_in               (req_addr_in),
      .req_smm_in                (req_smm_in),
      .dec_valid_out             (dec_valid_out),
      .dec_addr_out              (dec_addr_out),
      .dec_to_dram_out           (dec_to_dram_out),
      .dec_to_link_out           (dec_to_link_out),
      .top_of_memory_size_out    (top_of_memory_size_out),
      .invalid_access_flag_out   (invalid_access_flag_out)
   );
   link_sink sink (.clk_in(clk_in), .rst_in(rst_in), .dec_valid_in(dec_valid_out),
      .dec_to_link_in(dec_to_link_out), .link_hits_out(link_hits));
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   task check(input [35:0] seen, input [35:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one edge between transfers, so no strobe is set twice in a step
   task go; begin @(posedge clk_in); #1; end endtask
   task wr(input [7:0] a, input [7:0] d);
      begin go; {cfg_wr_in, cfg_addr_in, cfg_wdata_in} = {1'b1, a, d}; go; cfg_wr_in = 1'b0; end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin go; {cfg_rd_in, cfg_addr_in} = {1'b1, a}; go; cfg_rd_in = 1'b0; check(cfg_rdata_out, e); end
   endtask
   task req(input [35:0] a, input s, input [35:0] e, input l);
      begin
         go; {req_valid_in, req_addr_in, req_smm_in} = {1'b1, a, s}; go; req_valid_in = 1'b0;
         check(dec_addr_out, e);
         check({dec_valid_out, dec_to_link_out, dec_to_dram_out}, {1'b1, l, !l});
         exp_links = exp_links + l;
      end
   endtask
   task end_of_test;
      begin
         if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // hang guard, far beyond the hundred or so cycles the run needs
   initial begin #100000; n_errors = n_errors + 1; end_of_test; end
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      {n_errors, check_count, exp_links} = 0;
      {rst_in, cfg_wr_in, cfg_rd_in, req_valid_in, req_smm_in, smm_lock_in, global_smram_enable_in} = 7'h41;
      {cfg_addr_in, cfg_wdata_in, req_addr_in, smm_open_in} = 53'h0;
      rows[0] = {36'h0FEDA0010, 1'b1, 36'h0000A0010, 1'b0};
      rows[1] = {36'h0FEDBFFFF, 1'b1, 36'h0000BFFFF, 1'b0};
      rows[2] = {36'h0FEDC0000, 1'b1, 36'h0FEDC0000, 1'b0};
      rows[3] = {36'h07FD00000, 1'b1, 36'h07FD00000, 1'b0};
      rows[4] = {36'h07FD00000, 1'b0, 36'h07FD00000, 1'b1};
      rows[5] = {36'h07FCFFFFF, 1'b0, 36'h07FCFFFFF, 1'b0};
      rows[6] = {36'h07FE00000, 1'b0, 36'h07FE00000, 1'b0};
      rows[7] = {36'h0FEDA0000, 1'b0, 36'h0FEDA0000, 1'b1};
      repeat (6) @(posedge clk_in);
      #1 rst_in = 1'b0;
      rd(8'h9E, 8'h38);
      rd(8'hA0, 8'h01);
      rd(8'hA1, 8'h00);
      check(top_of_memory_size_out, 10'h001);
      wr(8'h9E, 8'h81);
      for (i = 0; i < 8; i = i + 1) req(rows[i][73:38], rows[i][37], rows[i][36:1], rows[i][0]);
      rd(8'h9E, 8'hF9);
      check(invalid_access_flag_out, 1'b1);
      wr(8'h9E, 8'h81);
      rd(8'h9E, 8'hF9);
      wr(8'h9E, 8'hC1);
      rd(8'h9E, 8'hB9);
      check(invalid_access_flag_out, 1'b0);
      // open while unlocked: still forwarded, but no flag one cycle later
      smm_open_in = 1'b1;
      req(36'h0FEDA0000, 1'b0, 36'h0FEDA0000, 1'b1);
      go;
      check(invalid_access_flag_out, 1'b0);
      smm_open_in = 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         base = 16'h07FE - ((i == 2) ? 16'h8 : (i == 1) ? 16'h2 : 16'h1);
         wr(8'h9E, {5'h10, i[1:0], 1'b1});
         req({base, 20'h0}, 1'b0, {base, 20'h0}, i != 3);
         req({base, 20'h0} - 36'h1, 1'b0, {base, 20'h0} - 36'h1, 1'b0);
      end
      wr(8'h9E, 8'hC0);
      req(36'h07FD00000, 1'b0, 36'h07FD00000, 1'b0);
      global_smram_enable_in = 1'b0;
      req(36'h0FEDA0010, 1'b1, 36'h0FEDA0010, 1'b0);
      global_smram_enable_in = 1'b1;
      wr(8'hA0, 8'h5A);
      wr(8'hA1, 8'hFF);
      rd(8'hA1, 8'h03);
      check(top_of_memory_size_out, 10'h35A);
      smm_lock_in = 1'b1;
      wr(8'hA0, 8'h00);
      wr(8'h9E, 8'h01);
      rd(8'h9E, 8'hB8);
      rd(8'hA0, 8'h5A);
      // open has no effect once locked: the flag must rise
      smm_open_in = 1'b1;
      req(36'h0FEDA0000, 1'b0, 36'h0FEDA0000, 1'b1);
      go;
      check(invalid_access_flag_out, 1'b1);
      // the sink counter clears on reset, so compare it before the second reset
      check(link_hits, exp_links);
      rst_in = 1'b1;
      repeat (2) go;
      {rst_in, smm_lock_in, smm_open_in} = 3'h0;
      rd(8'h9E, 8'h38);
      check(top_of_memory_size_out, 10'h001);
      end_of_test;
   end
endmodule

/* File: tb/link_sink.sv */
`timescale 1ns/1ps
// downstream link stand-in: always accepts, counts what it is handed
module link_sink (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        dec_valid_in,
   input  wire        dec_to_link_in,
   output reg  [31:0] link_hits_out
);
   // counted on the single cycle the decode stands, so none is missed
   always @(posedge clk_in) begin
      if (rst_in) link_hits_out <= 32'h0;
      else if (dec_valid_in && dec_to_link_in) link_hits_out <= link_hits_out + 32'h1;
   end
endmodule

/* File: tb/smram_decode_sva.sv */
`timescale 1ns/1ps
module smram_decode_sva (
   // clock and reset
   input wire        clk_in,
   input wire        rst_in,
   // watched ports
   input wire        cfg_wr_in,
   input wire        cfg_rd_in,
   input wire [7:0]  cfg_addr_in,
   input wire [7:0]  cfg_wdata_in,
   input wire [7:0]  cfg_rdata_out,
   input wire        global_smram_enable_in,
   input wire        smm_lock_in,
   input wire        smm_open_in,
   input wire        req_valid_in,
   input wire [35:0] req_addr_in,
   input wire        dec_valid_out,
   input wire [35:0] dec_addr_out,
   input wire        dec_to_dram_out,
   input wire        dec_to_link_out,
   input wire [9:0]  top_of_memory_size_out,
   input wire        invalid_access_flag_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // flag clear write, then no fresh violation in the cycle it lands
   sequence clear_wr; cfg_wr_in && cfg_addr_in == 8'h9E && cfg_wdata_in[6]; endsequence
   sequence no_hit; !(dec_valid_out && dec_to_link_out); endsequence
   cache_bits_a: assert property (cfg_rd_in && cfg_addr_in == 8'h9E |=> cfg_rdata_out[5:3] == 3'h7)
      else $error("cache bits read low");
   dec_latency_a: assert property (1'b1 |=> dec_valid_out == $past(req_valid_in))
      else $error("decode not one cycle after request");
   one_target_a: assert property (dec_valid_out |-> dec_to_dram_out != dec_to_link_out)
      else $error("decode target not unique");
   global_off_a: assert property (req_valid_in && !global_smram_enable_in |=> dec_to_dram_out && dec_addr_out == $past(req_addr_in))
      else $error("extended decode active without global enable");
   addr_remap_a: assert property (req_valid_in |=> dec_addr_out == $past(req_addr_in) || dec_addr_out == $past(req_addr_in) - 36'h0FED00000)
      else $error("bad remapped address");
   flag_set_a: assert property (dec_valid_out && dec_to_link_out && (!$past(smm_open_in) || $past(smm_lock_in)) |=> invalid_access_flag_out)
      else $error("flag not set by non-SMM access");
   flag_hold_a: assert property ($fell(invalid_access_flag_out) |-> $past(cfg_wr_in, 2) && $past(cfg_wdata_in[6], 2) && $past(cfg_addr_in, 2) == 8'h9E)
      else $error("flag dropped without clear write");
   flag_clear_a: assert property (clear_wr ##1 no_hit |=> !invalid_access_flag_out)
      else $error("flag not cleared");
   size_write_a: assert property (cfg_wr_in && cfg_addr_in == 8'hA0 && !smm_lock_in |=> ##1 top_of_memory_size_out[7:0] == $past(cfg_wdata_in, 2))
      else $error("memory size not written");
   size_lock_a: assert property (cfg_wr_in && cfg_addr_in == 8'hA0 && smm_lock_in |=> ##1 $stable(top_of_memory_size_out))
      else $error("locked memory size changed");
   upper_zero_a: assert property (cfg_rd_in && cfg_addr_in == 8'hA1 |=> cfg_rdata_out[7:2] == 6'h00)
      else $error("reserved size bits nonzero");
endmodule
bind extended_smram_decode_control smram_decode_sva chk (
   .clk_in                  (clk_in),
   .rst_in                  (rst_in),
   .cfg_wr_in               (cfg_wr_in),
   .cfg_rd_in               (cfg_rd_in),
   .cfg_addr_in             (cfg_addr_in),
   .cfg_wdata_in            (cfg_wdata_in),
   .cfg_rdata_out           (cfg_rdata_out),
   .global_smram_enable_in  (global_smram_enable_in),
   .smm_lock_in             (smm_lock_in),
   .smm_open_in             (smm_open_in),
   .req_valid_in            (req_valid_in),
   .req_addr_in             (req_addr_in),
   .dec_valid_out           (dec_valid_out),
   .dec_addr_out            (dec_addr_out),
   .dec_to_dram_out         (dec_to_dram_out),
   .dec_to_link_out         (dec_to_link_out),
   .top_of_memory_size_out  (top_of_memory_size_out),
   .invalid_access_flag_out (invalid_access_flag_out)
);
